// ### hw/sdc_config_regs.sv
// Configuration bank of the switch detect interface, written by serial frames
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Enabled input change: interrupt, or wake asleep
// - Commands 02/03 load wake enables
// - All registers writable any time, normal mode
// - Level bit 0 selects low current
// - Level bit 1 selects high current
// - Commands 04/05 load wetting level bits
// - Per-input 20 ms timer restarts on change
// - Timer expiry drops high to low current
// - Disabled timer keeps high current
// - Timer enable bit 1 enables reduction
// - Commands 07/08 load timer enables
// - Tri-state bit forces high impedance on inputs not analog selected
// - Tri-stated input still reports its state
// - Channel field routes one input to mux
// - Selected analog input reports 0 in status
// - Current field: 00 off, 01 low, 10 high
// - Current code 11 treated as high impedance
// - Analog currents are always pull-up
// - Frames are 24 bits, MSB first, duplex
// - Writes only in normal mode with supply
// - Channel 1-14 ground, 15-22 programmable
// - Reset sets enables, levels, tri-state; channel 0
module sdc_config_regs
   import sdc_pkg::*;
#(
   parameter int WET_TIMER_CYCLES = WET_CYCLES
) (
   input  wire logic                         core_clk,
   input  wire logic                         srst,
   input  wire logic                         sclk,
   input  wire logic                         cs_n,
   input  wire logic                         mosi,
   output logic                              miso,
   output logic                              miso_oe_n,
   output logic                              int_n,
   output logic                              wake_req,
   input  wire logic                         normal_mode,
   input  wire logic                         vdd_present,
   input  wire logic [sdc_pkg::NUM_IN-1:0]   sw_closed,
   output logic      [sdc_pkg::NUM_IN-1:0]   src_on,
   output logic      [sdc_pkg::NUM_IN-1:0]   src_high,
   output logic      [sdc_pkg::NUM_PROG-1:0] src_pullup_force,
   output logic      [4:0]                   analog_mux_out,
   output logic                              analog_mux_out_en
);
   import sdc_pkg::*;

   // ----------------------------------------------------------------
   // Link side
   // ----------------------------------------------------------------
   logic [FRAME_BITS-1:0] rx_word;
   logic                  rx_done;
   logic [FRAME_BITS-1:0] resp_q, resp_d;

   // Duplex shifter; response is shifted out while the command shifts in
   sdc_spi_link u_link (
      .sclk (sclk),
      .cs_n (cs_n),
      .mosi (mosi),
      .resp (resp_q),
      .miso (miso),
      .word (rx_word),
      .done (rx_done)
   );

   // Output enable is low while the frame drives the data line
   assign miso_oe_n = cs_n;

   // ----------------------------------------------------------------
   // Synchronisers into the core clock
   // ----------------------------------------------------------------
   logic [2:0]        cs_sync_q, cs_sync_d;
   logic [2:0]        done_sync_q, done_sync_d;
   logic [NUM_IN-1:0] sw_s1_q, sw_s2_q, sw_s3_q;
   logic [NUM_IN-1:0] sw_s1_d, sw_s2_d, sw_s3_d;
   logic              cs_fall, cs_rise, commit_pulse, commit;
   logic [NUM_IN-1:0] sw_chg;

   // Stage one is only read by stage two; edges come from stages two and three
   always_comb begin
      cs_sync_d   = {cs_sync_q[1:0], cs_n};
      done_sync_d = {done_sync_q[1:0], rx_done};
      sw_s1_d     = sw_closed;
      sw_s2_d     = sw_s1_q;
      sw_s3_d     = sw_s2_q;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cs_sync_q   <= 3'h7;
         done_sync_q <= 3'h0;
         sw_s1_q     <= '0;
         sw_s2_q     <= '0;
         sw_s3_q     <= '0;
      end else begin
         cs_sync_q   <= cs_sync_d;
         done_sync_q <= done_sync_d;
         sw_s1_q     <= sw_s1_d;
         sw_s2_q     <= sw_s2_d;
         sw_s3_q     <= sw_s3_d;
      end
   end

   assign cs_fall      = cs_sync_q[2] & ~cs_sync_q[1];
   assign cs_rise      = ~cs_sync_q[2] & cs_sync_q[1];
   // The word is stable in the link domain once done has crossed
   assign commit_pulse = done_sync_q[1] & ~done_sync_q[2];
   assign commit       = commit_pulse & normal_mode & vdd_present;
   // A comparator edge in either direction is a threshold crossing
   assign sw_chg       = sw_s2_q ^ sw_s3_q;

   // ----------------------------------------------------------------
   // Register bank
   // ----------------------------------------------------------------
   logic [NUM_IN-1:0] wake_en_q, wake_en_d;
   logic [NUM_IN-1:0] level_q, level_d;
   logic [NUM_IN-1:0] timer_en_q, timer_en_d;
   logic [NUM_IN-1:0] tri_q, tri_d;
   logic [ANA_W-1:0]  analog_q, analog_d;
   logic [7:0]        cmd;

   assign cmd = rx_word[FRAME_BITS-1:FRAME_BITS-8];

   // Decode one committed frame; payload bits outside each field are dropped
   always_comb begin
      wake_en_d  = wake_en_q;
      level_d    = level_q;
      timer_en_d = timer_en_q;
      tri_d      = tri_q;
      analog_d   = analog_q;
      if (commit) begin
         case (cmd)
            CMD_WAKE_PROG:  wake_en_d[NUM_IN-1:PROG_BASE]  = rx_word[NUM_PROG-1:0];
            CMD_WAKE_GND:   wake_en_d[NUM_GND-1:0]         = rx_word[NUM_GND-1:0];
            CMD_LEVEL_PROG: level_d[NUM_IN-1:PROG_BASE]    = rx_word[NUM_PROG-1:0];
            CMD_LEVEL_GND:  level_d[NUM_GND-1:0]           = rx_word[NUM_GND-1:0];
            CMD_TIMER_PROG: timer_en_d[NUM_IN-1:PROG_BASE] = rx_word[NUM_PROG-1:0];
            CMD_TIMER_GND:  timer_en_d[NUM_GND-1:0]        = rx_word[NUM_GND-1:0];
            CMD_TRI_PROG:   tri_d[NUM_IN-1:PROG_BASE]      = rx_word[NUM_PROG-1:0];
            CMD_TRI_GND:    tri_d[NUM_GND-1:0]             = rx_word[NUM_GND-1:0];
            CMD_ANALOG:     analog_d                       = rx_word[ANA_W-1:0];
            default: ;
         endcase
      end
   end

   // Reset defaults: everything enabled, all inputs floating, no channel
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wake_en_q  <= RST_ALL_SET;
         level_q    <= RST_ALL_SET;
         timer_en_q <= RST_ALL_SET;
         tri_q      <= RST_ALL_SET;
         analog_q   <= RST_ANALOG;
      end else begin
         wake_en_q  <= wake_en_d;
         level_q    <= level_d;
         timer_en_q <= timer_en_d;
         tri_q      <= tri_d;
         analog_q   <= analog_d;
      end
   end

   // ----------------------------------------------------------------
   // Wetting timers, one per input
   // ----------------------------------------------------------------
   logic [NUM_IN-1:0] expired;

   for (genvar i = 0; i < NUM_IN; i++) begin : g_timer
      sdc_wet_timer #(
         .CYCLES (WET_TIMER_CYCLES)
      ) u_timer (
         .core_clk (core_clk),
         .srst     (srst),
         .restart  (sw_chg[i]),
         .expired  (expired[i])
      );
   end

   // ----------------------------------------------------------------
   // Analog channel decode and current sources
   // ----------------------------------------------------------------
   logic [4:0]        chan;
   logic [1:0]        cur_sel;
   logic [NUM_IN-1:0] sel_vec;
   logic              ana_on;
   logic [NUM_IN-1:0] on_q, on_d, high_q, high_d;
   logic [NUM_PROG-1:0] pull_q, pull_d;
   logic [4:0]        mux_q, mux_d;
   logic              analog_mux_out_q, analog_mux_out_d;

   assign chan    = analog_q[ANA_CH_MSB:0];
   assign cur_sel = analog_q[ANA_CUR_MSB:ANA_CUR_LSB];

   // Channel code n selects vector index n-1; codes past the last select none
   always_comb begin
      sel_vec = '0;
      if (chan != CH_NONE && chan <= CH_LAST) begin
         sel_vec[chan - 5'h01] = 1'b1;
      end
   end

   // Code 11 is not a current, so it falls to high impedance with 00
   assign ana_on = (cur_sel == CUR_LOW) || (cur_sel == CUR_HIGH);

   // Per input: tri-state wins, then level and timer; analog select overrides
   always_comb begin
      on_d   = (~tri_q & ~sel_vec) | (sel_vec & {NUM_IN{ana_on}});
      // Level 0 gives low current, level 1 high until an enabled timer ends
      high_d = (level_q & ~(timer_en_q & expired) & ~sel_vec)
             | (sel_vec & {NUM_IN{cur_sel == CUR_HIGH}});
      // The selected programmable input is forced to pull-up while its analog current runs
      pull_d = sel_vec[NUM_IN-1:PROG_BASE] & {NUM_PROG{ana_on}};
      mux_d  = (chan <= CH_LAST) ? chan : CH_NONE;
      analog_mux_out_d = |sel_vec;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         on_q   <= '0;
         high_q <= '0;
         pull_q <= '0;
         mux_q  <= CH_NONE;
         analog_mux_out_q <= 1'b0;
      end else begin
         on_q   <= on_d;
         high_q <= high_d;
         pull_q <= pull_d;
         mux_q  <= mux_d;
         analog_mux_out_q <= analog_mux_out_d;
      end
   end

   assign src_on           = on_q;
   assign src_high         = high_q;
   assign src_pullup_force = pull_q;
   assign analog_mux_out   = mux_q;
   assign analog_mux_out_en          = analog_mux_out_q;

   // ----------------------------------------------------------------
   // Interrupt, wake and status response
   // ----------------------------------------------------------------
   logic [NUM_IN-1:0] chg_en;
   logic              int_set;
   logic              int_q, int_d, infr_q, infr_d, wake_q, wake_d;

   assign chg_en  = sw_chg & wake_en_q;
   assign int_set = (|chg_en) & normal_mode;

   // A change inside the frame keeps the flag past chip select rising,
   // and a set in the clearing cycle wins so no edge is lost
   always_comb begin
      int_d  = int_q;
      infr_d = infr_q;
      if (cs_rise) begin
         infr_d = 1'b0;
         if (!infr_q) begin
            int_d = 1'b0;
         end
      end
      if (int_set) begin
         int_d = 1'b1;
         if (!cs_sync_q[1]) begin
            infr_d = 1'b1;
         end
      end
      wake_d = (|chg_en) & ~normal_mode;
   end

   // Snapshot at frame start; tri-stated inputs still report, selected reads 0
   always_comb begin
      resp_d = resp_q;
      if (cs_fall) begin
         resp_d = {int_q, 1'b0, sw_s2_q & ~sel_vec};
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         int_q  <= 1'b0;
         infr_q <= 1'b0;
         wake_q <= 1'b0;
         resp_q <= '0;
      end else begin
         int_q  <= int_d;
         infr_q <= infr_d;
         wake_q <= wake_d;
         resp_q <= resp_d;
      end
   end

   assign int_n    = ~int_q;
   assign wake_req = wake_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence s_commit_cmd(logic [7:0] c);
      commit && cmd == c;
   endsequence

   a_wake_prog_load: assert property (s_commit_cmd(CMD_WAKE_PROG) |=>
      wake_en_q[NUM_IN-1:PROG_BASE] == $past(rx_word[NUM_PROG-1:0]))
      else $error("wake enable programmable half not loaded");

   a_level_gnd_load: assert property (s_commit_cmd(CMD_LEVEL_GND) |=>
      level_q[NUM_GND-1:0] == $past(rx_word[NUM_GND-1:0]) && $stable(wake_en_q))
      else $error("wetting level ground half not loaded");

   a_write_gated: assert property (commit_pulse && !normal_mode |=>
      $stable(tri_q) && $stable(analog_q) && $stable(level_q))
      else $error("register changed outside normal mode");

   a_int_cause: assert property ($rose(int_q) |-> $past(|(sw_chg & wake_en_q)))
      else $error("interrupt raised without enabled change");

   a_int_raise: assert property (int_set |=> int_q ##1 int_q)
      else $error("enabled change did not raise interrupt");

   a_tri_off: assert property (##1 1'b1 |->
      (on_q & $past(tri_q) & ~$past(sel_vec)) == '0)
      else $error("tri-stated input has current on");

   a_bad_cur_hiz: assert property (cur_sel == 2'h3 && analog_mux_out_d |=>
      (on_q & $past(sel_vec)) == '0)
      else $error("current code 11 did not give high impedance");

   a_status_mask: assert property (cs_fall |=>
      (resp_q[NUM_IN-1:0] & $past(sel_vec)) == '0)
      else $error("selected analog input reported closed");

   a_timer_drop: assert property (##1 1'b1 |->
      (high_q & $past(timer_en_q & expired & ~sel_vec)) == '0)
      else $error("expired timer kept high current");

endmodule // sdc_config_regs
`default_nettype wire

// ### hw/sdc_pkg.sv
// Shared constants for the switch detect configuration bank
package sdc_pkg;

   // ----------------------------------------------------------------
   // Input counts and frame shape
   // ----------------------------------------------------------------
   localparam int NUM_PROG   = 8;
   localparam int NUM_GND    = 14;
   localparam int NUM_IN     = NUM_PROG + NUM_GND;
   localparam int FRAME_BITS = 24;
   localparam int CNT_W      = 5;
   localparam logic [CNT_W-1:0] LAST_BIT = 5'h17;   // Bit index of the 24th bit
   localparam logic [CNT_W-1:0] FULL_CNT = 5'h18;   // Saturation after 24 bits

   // Vector layout: ground-only inputs at 0..13, programmable at 14..21
   localparam int PROG_BASE = NUM_GND;

   // ----------------------------------------------------------------
   // Command bytes (frame bits 23:16)
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_WAKE_PROG  = 8'h02;
   localparam logic [7:0] CMD_WAKE_GND   = 8'h03;
   localparam logic [7:0] CMD_LEVEL_PROG = 8'h04;
   localparam logic [7:0] CMD_LEVEL_GND  = 8'h05;
   localparam logic [7:0] CMD_ANALOG     = 8'h06;
   localparam logic [7:0] CMD_TIMER_PROG = 8'h07;
   localparam logic [7:0] CMD_TIMER_GND  = 8'h08;
   localparam logic [7:0] CMD_TRI_PROG   = 8'h09;
   localparam logic [7:0] CMD_TRI_GND    = 8'h0A;

   // ----------------------------------------------------------------
   // Analog select fields and codes
   // ----------------------------------------------------------------
   localparam int ANA_W       = 7;
   localparam int ANA_CUR_MSB = 6;
   localparam int ANA_CUR_LSB = 5;
   localparam int ANA_CH_MSB  = 4;
   localparam logic [1:0] CUR_HIZ  = 2'h0;
   localparam logic [1:0] CUR_LOW  = 2'h1;
   localparam logic [1:0] CUR_HIGH = 2'h2;
   localparam logic [4:0] CH_NONE  = 5'h00;
   localparam logic [4:0] CH_LAST  = 5'h16;

   // ----------------------------------------------------------------
   // Reset values and response layout
   // ----------------------------------------------------------------
   localparam logic [NUM_IN-1:0] RST_ALL_SET = 22'h3FFFFF;
   localparam logic [ANA_W-1:0]  RST_ANALOG  = 7'h00;
   localparam int RESP_INT_BIT = 23;

   // ----------------------------------------------------------------
   // Wetting timer
   // ----------------------------------------------------------------
   localparam int CORE_CLK_HZ = 100_000_000;
   localparam int WET_TIME_MS = 20;
   localparam int WET_CYCLES  = WET_TIME_MS * (CORE_CLK_HZ / 1000);

endpackage : sdc_pkg

// ### hw/sdc_wet_timer.sv
// One per-input wetting current timer
`timescale 1ns/100ps
`default_nettype none
module sdc_wet_timer
   import sdc_pkg::*;
#(
   parameter int CYCLES = WET_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic restart,
   output logic      expired
);
   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt_q, cnt_d;
   logic          run_q, run_d;
   logic          exp_q, exp_d;

   // Restart wins over a running count, so a bouncing contact keeps 16 mA
   always_comb begin
      cnt_d = cnt_q;
      run_d = run_q;
      exp_d = exp_q;
      if (restart) begin
         cnt_d = '0;
         run_d = 1'b1;
         exp_d = 1'b0;
      end else if (run_q) begin
         if (cnt_q == CW'(CYCLES - 1)) begin
            run_d = 1'b0;
            exp_d = 1'b1;
         end else begin
            cnt_d = cnt_q + CW'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         run_q <= run_d;
         exp_q <= exp_d;
      end
   end

   assign expired = exp_q;
endmodule // sdc_wet_timer
`default_nettype wire

// ### hw/sdc_spi_link.sv
// Serial link shifter on the host's serial clock
`timescale 1ns/100ps
`default_nettype none
module sdc_spi_link
   import sdc_pkg::*;
(
   input  wire logic                  sclk,
   input  wire logic                  cs_n,
   input  wire logic                  mosi,
   input  wire logic [FRAME_BITS-1:0] resp,
   output logic                       miso,
   output logic [FRAME_BITS-1:0]      word,
   output logic                       done
);
   logic [CNT_W-1:0]      cnt_q, cnt_d;
   logic [FRAME_BITS-2:0] shift_q, shift_d;
   logic [FRAME_BITS-1:0] word_q, word_d;
   logic                  done_q, done_d;
   logic                  miso_q, miso_d;

   // Shift in MSB first; bits past the 24th are dropped
   always_comb begin
      cnt_d   = cnt_q;
      shift_d = {shift_q[FRAME_BITS-3:0], mosi};
      word_d  = word_q;
      done_d  = done_q;
      if (cnt_q != FULL_CNT) begin
         cnt_d = cnt_q + CNT_W'(1);
      end
      if (cnt_q == LAST_BIT) begin
         word_d = {shift_q, mosi};
         done_d = 1'b1;
      end
   end

   // The clock stops between frames, so chip select itself ends the frame
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         cnt_q   <= '0;
         shift_q <= '0;
         done_q  <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         done_q  <= done_d;
      end
   end

   // Word holds after the frame so the core can read it once done is seen
   always_ff @(posedge sclk) begin
      word_q <= word_d;
   end

   // Next response bit; resp is a snapshot that stays still during the frame
   always_comb begin
      miso_d = (cnt_q < FULL_CNT) ? resp[LAST_BIT - cnt_q] : 1'b0;
   end

   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         miso_q <= 1'b0;
      end else begin
         miso_q <= miso_d;
      end
   end

   assign miso = (cnt_q == '0) ? resp[FRAME_BITS-1] : miso_q;
   assign word = word_q;
   assign done = done_q;
endmodule // sdc_spi_link
`default_nettype wire

// ### testbench/sdc_host_model.sv
// Host serial master model that drives 24-bit mode 0 frames
`timescale 1ns/100ps
`default_nettype none
module sdc_host_model (
   input  wire logic link_clk,
   input  wire logic miso,
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi
);
   logic gate = 1'b0;

   // Serial clock only runs inside a frame, it stands still between them
   assign sclk = gate & link_clk;

   // Select starts low and rises once, so the link's async clear runs before any frame
   initial begin
      cs_n = 1'b0;
      mosi = 1'b0;
      #2 cs_n = 1'b1;
   end

   // One whole frame; the long select margins let the core see both edges
   task automatic xfer(input logic [23:0] w, output logic [23:0] r);
      @(negedge link_clk);
      cs_n <= 1'b0;
      repeat (8) @(negedge link_clk);
      for (int i = 23; i >= 0; i--) begin
         mosi <= w[i];
         gate <= 1'b1;
         @(posedge link_clk);
         r[i] = miso;
         @(negedge link_clk);
      end
      gate <= 1'b0;
      mosi <= ~mosi;  // Released data line must not keep the last bit
      repeat (8) @(negedge link_clk);
      cs_n <= 1'b1;
      repeat (8) @(negedge link_clk);
   endtask
endmodule // sdc_host_model
`default_nettype wire

// ### testbench/sdc_config_regs_tb.sv
// Self-checking bench for the switch detect configuration bank
`timescale 1ns/100ps
`default_nettype none
module sdc_config_regs_tb;
   import sdc_pkg::*;
   localparam int WT = 20;  // Short wetting time keeps the run brief
   logic                core_clk    = 1'b0;
   logic                link_clk    = 1'b0;
   logic                srst        = 1'b1;
   logic                normal_mode = 1'b1;
   logic                vdd_present = 1'b1;
   logic [NUM_IN-1:0]   sw_closed   = '0;
   logic                sclk, cs_n, mosi, miso, miso_oe_n, int_n, wake_req, analog_mux_out_en;
   logic [NUM_IN-1:0]   src_on, src_high;
   logic [NUM_PROG-1:0] src_pullup_force;
   logic [4:0]          analog_mux_out, ch;
   logic [1:0]          cur;
   logic [23:0]         rsp;
   logic                seen, ok, act;
   logic [6:0]          ana [4] = '{7'h21, 7'h56, 7'h6F, 7'h17};
   int                  idx;
   int                  failures = 0;
   int                  checks = 0;

   // ----------------------------------------------------------------
   // Clocks, design and host
   // ----------------------------------------------------------------
   always #5 core_clk = ~core_clk;
   // Link clock offset so its edges never line up with the core clock
   initial begin
      #1.3;
      forever #3 link_clk = ~link_clk;
   end

   sdc_config_regs #(.WET_TIMER_CYCLES(WT)) dut (
      .core_clk(core_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .miso(miso), .miso_oe_n(miso_oe_n), .int_n(int_n), .wake_req(wake_req),
      .normal_mode(normal_mode), .vdd_present(vdd_present), .sw_closed(sw_closed),
      .src_on(src_on), .src_high(src_high), .src_pullup_force(src_pullup_force),
      .analog_mux_out(analog_mux_out), .analog_mux_out_en(analog_mux_out_en)
   );

   sdc_host_model host (
      .link_clk(link_clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Frame write, then room for the commit to reach the outputs
   task automatic wr(input logic [7:0] cmd, input logic [15:0] val);
      host.xfer({cmd, val}, rsp);
      repeat (4) @(posedge core_clk);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (6000) @(posedge core_clk);
      failures++;
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge core_clk);
      srst <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk(src_on, '0, "reset tri-state");
      chk(src_high, RST_ALL_SET, "reset level");
      chk({analog_mux_out_en, analog_mux_out}, '0, "reset channel");
      chk(miso_oe_n, 1'b1, "data line released when idle");
      // Don't-care bits set high must not leak into the registers
      wr(CMD_TRI_GND, 16'hC000);
      wr(CMD_TRI_PROG, 16'hFF00);
      chk(src_on, {NUM_IN{1'b1}}, "tri-state cleared");
      wr(CMD_LEVEL_GND, 16'h2AAA);
      wr(CMD_LEVEL_PROG, 16'h000F);
      chk(src_high, {8'h0F, 14'h2AAA}, "level bits");
      wr(CMD_LEVEL_GND, 16'h3FFF);
      wr(CMD_LEVEL_PROG, 16'h00FF);
      wr(CMD_TIMER_GND, 16'h3FFE);
      // Input 0 has its timer off, input 1 keeps it on
      @(posedge core_clk);
      sw_closed[1:0] <= 2'b11;
      repeat (10) @(posedge core_clk);
      chk(src_high[1:0], 2'b11, "before expiry");
      chk(int_n, 1'b0, "change raises interrupt");
      repeat (30) @(posedge core_clk);
      chk(src_high[1:0], 2'b01, "after expiry");
      wr(CMD_WAKE_GND, 16'h0000);
      chk(rsp[23:22], 2'b10, "interrupt flag in response");
      @(posedge core_clk);
      sw_closed[2] <= 1'b1;
      repeat (8) @(posedge core_clk);
      chk(int_n, 1'b1, "masked change");
      // Programmable halves: input 0 loses wake, all lose the timed drop
      wr(CMD_WAKE_PROG, 16'h00FE);
      wr(CMD_TIMER_PROG, 16'h0000);
      // Asleep: enabled change wakes, register writes are dropped
      normal_mode <= 1'b0;
      sw_closed[15] <= 1'b1;
      seen = 1'b0;
      // Sampled mid-cycle so the one-cycle pulse is seen while it stands
      repeat (8) begin
         @(negedge core_clk);
         if (wake_req === 1'b1) begin
            seen = 1'b1;
         end
      end
      chk(seen, 1'b1, "wake pulse");
      wr(CMD_TRI_GND, 16'h3FFF);
      chk(src_on, {NUM_IN{1'b1}}, "sleep write dropped");
      normal_mode <= 1'b1;
      // Analog codes: low, high, forbidden, out-of-range channel
      foreach (ana[k]) begin
         ch = ana[k][4:0];
         cur = ana[k][6:5];
         idx = int'(ch) - 1;
         ok = (ch >= 5'h01) && (ch <= CH_LAST);
         act = (cur == CUR_LOW) || (cur == CUR_HIGH);
         wr(CMD_ANALOG, {9'h1FF, ana[k]});
         chk({analog_mux_out_en, analog_mux_out}, ok ? {1'b1, ch} : 6'h00, "channel");
         if (ok) begin
            chk({src_on[idx], src_on[idx] & src_high[idx]}, {act, cur == CUR_HIGH}, "current");
            chk(src_pullup_force, (idx >= PROG_BASE && act) ? 8'h01 << (idx - PROG_BASE) : 8'h00,
                "pull-up");
         end
      end
      chk(src_high[15], 1'b1, "programmable timer off keeps high");
      // A tri-stated closed input must still report closed
      wr(CMD_TRI_GND, 16'h0004);
      chk(src_on[2], 1'b0, "tri-stated input off");
      wr(CMD_ANALOG, 16'h0001);
      fork
         host.xfer({8'h0B, 16'h0000}, rsp);
         begin
            @(negedge cs_n);
            @(posedge core_clk);
            chk(miso_oe_n, 1'b0, "data line driven in frame");
         end
      join
      chk(rsp, {2'b00, sw_closed & ~22'h000001}, "selected input reads 0");
      chk(analog_mux_out, 5'h01, "unknown command");
      tally_and_finish();
   end
endmodule // sdc_config_regs_tb
`default_nettype wire
